/* File: logic/trap_ctl_pkg.sv */
// trap_ctl_pkg: constants and carrier types for the trap category controller
// assumes a 64-bit counter width and a two-level supervisor nesting stack
package trap_ctl_pkg;
   localparam int PC_W          = 64;
   localparam int LEVEL_W       = 4;
   localparam int TL_W          = 3;
   localparam int NUM_IRQ       = 15;
   localparam int TT_W          = 9;
   localparam int STACK_DEPTH   = 8;
   localparam logic [TL_W-1:0]  MAX_SUPERVISOR_NESTING = 3'h2;
   localparam logic [TL_W-1:0]  MAX_TRAP_LEVEL         = 3'h6;
   localparam logic [PC_W-1:0]  INSTR_BYTES   = 64'h0000000000000004;
   localparam logic [PC_W-1:0]  RESET_VECTOR  = 64'h0000000000000020;
   localparam logic [LEVEL_W-1:0] THRESH_RESET = 4'hF;
   // register offsets
   localparam logic [3:0] REG_CTRL      = 4'h0;
   localparam logic [3:0] REG_SOFT_INTERRUPT_REQUEST_REG   = 4'h1;
   localparam logic [3:0] REG_SOFTCLR   = 4'h2;
   localparam logic [3:0] REG_STATUS    = 4'h3;
   localparam logic [3:0] REG_DEFINFO   = 4'h4;
   localparam logic [3:0] REG_TTYPE     = 4'h5;
   // control field positions
   localparam int CTRL_IE_BIT    = 0;
   localparam int CTRL_PIL_LSB   = 4;
   localparam int CTRL_PRIV_LSB  = 8;
   // trap type codes for the events this block raises itself
   localparam logic [TT_W-1:0] TT_RESET      = 9'h001;
   localparam logic [TT_W-1:0] TT_TERM_DEF   = 9'h002;
   localparam logic [TT_W-1:0] TT_RESTART_DEF= 9'h003;
   localparam logic [TT_W-1:0] TT_PRECISE    = 9'h004;
   localparam logic [TT_W-1:0] TT_HYPER_INT  = 9'h005;
   localparam logic [TT_W-1:0] TT_IRQ_BASE   = 9'h040;

   typedef enum logic [1:0] {
      MODE_USER  = 2'b00,
      MODE_PRIV  = 2'b01,
      MODE_HYPER = 2'b10
   } priv_mode_t;

   typedef enum logic [2:0] {
      CAT_NONE      = 3'b000,
      CAT_RESET     = 3'b001,
      CAT_PRECISE   = 3'b010,
      CAT_TERM_DEF  = 3'b011,
      CAT_RSTRT_DEF = 3'b100,
      CAT_DISRUPT   = 3'b101
   } trap_cat_t;

   typedef enum logic [1:0] {
      RET_NONE  = 2'b00,
      RET_RETRY = 2'b01,
      RET_DONE  = 2'b10
   } ret_kind_t;

   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [PC_W-1:0] next_program_counter;
   } pc_pair_t;

   typedef struct packed {
      logic             valid;
      trap_cat_t        cat;
      logic [TT_W-1:0]  tt;
      logic             to_hyper;
      pc_pair_t         saved;
      logic [TL_W-1:0]  level;
   } trap_take_t;
endpackage : trap_ctl_pkg

/* File: logic/irq_sync.sv */
// irq_sync: three-stage synchroniser per external interrupt line
// assumes lines are asynchronous levels held by their sources
`timescale 1ns/1ps
module irq_sync
   import trap_ctl_pkg::*;
(
   input  wire logic               core_clk_in,
   input  wire logic               nrst_in,
   input  wire logic [NUM_IRQ-1:0] raw_in,
   output logic      [NUM_IRQ-1:0] level_out
);
   genvar g;
   generate
      for (g = 0; g < NUM_IRQ; g++) begin : g_line
         logic [2:0] stage_reg;
         always_ff @(posedge core_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
               stage_reg <= 3'h0;
               level_out[g] <= 1'b0;
            end else begin
               stage_reg <= {stage_reg[1:0], raw_in[g]};
               // change counts once stages two and three agree
               if (stage_reg[1] == stage_reg[2])
                  level_out[g] <= stage_reg[2];
            end
         end
      end
   endgenerate
endmodule : irq_sync

/* File: logic/trap_stack.sv */
// trap_stack: saved counter pairs, one entry per trap level
// assumes one write or one read per cycle; read data are registered
`timescale 1ns/1ps
module trap_stack
   import trap_ctl_pkg::*;
(
   input  wire logic            core_clk_in,
   input  wire logic [TL_W-1:0] wr_addr_in,
   input  wire logic            wr_en_in,
   input  wire pc_pair_t        wr_data_in,
   input  wire logic [TL_W-1:0] rd_addr_in,
   output pc_pair_t             rd_data_out
);
   pc_pair_t mem [STACK_DEPTH];

   always_ff @(posedge core_clk_in) begin
      if (wr_en_in)
         mem[wr_addr_in] <= wr_data_in;
      rd_data_out <= mem[rd_addr_in];
   end
endmodule : trap_stack

/* File: logic/trap_category_control.sv */
// trap_category_control: classifies and takes traps at instruction edges
// assumes pipeline holds issue while trap_take_out or ret_busy_out is high
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module trap_category_control
   import trap_ctl_pkg::*;
(
   input  wire logic               core_clk_in,
   input  wire logic               nrst_in,
   // register port
   input  wire logic [3:0]         reg_addr_in,
   input  wire logic [31:0]        reg_wdata_in,
   input  wire logic               reg_wr_in,
   input  wire logic               reg_rd_in,
   output logic      [31:0]        reg_rdata_out,
   // pipeline
   input  wire logic               boundary_in,
   input  wire pc_pair_t           cur_pc_in,
   input  wire logic               exc_valid_in,
   input  wire logic [TT_W-1:0]    exc_tt_in,
   input  wire logic               multi_load_first_in,
   input  wire logic               term_def_in,
   input  wire logic               rstrt_def_in,
   input  wire pc_pair_t           def_pc_in,
   input  wire logic               drain_def_in,
   input  wire logic               ret_retry_in,
   input  wire logic               ret_done_in,
   // interrupt sources
   input  wire logic [NUM_IRQ-1:0] ext_irq_in,
   input  wire logic               hyper_irq_in,
   input  wire logic               sys_reset_req_in,
   // outcome
   output trap_take_t              trap_take_out,
   output logic                    flush_younger_out,
   output logic                    commit_block_out,
   output logic                    redirect_out,
   output pc_pair_t                redirect_pc_out,
   output logic                    ret_busy_out,
   output priv_mode_t              priv_out,
   output logic [TL_W-1:0]         trap_nesting_level_out
);
   logic [NUM_IRQ-1:0]   ext_level;
   logic [NUM_IRQ:1]     soft_interrupt_request_reg;
   logic                 global_interrupt_enable_reg;
   logic [LEVEL_W-1:0]   processor_interrupt_threshold_reg;
   priv_mode_t           priv_reg;
   logic [TL_W-1:0]      trap_nesting_level_reg;
   logic                 def_pend_reg;
   logic                 def_term_reg;
   pc_pair_t             def_pc_reg;
   priv_mode_t           def_mode_reg;
   logic [TT_W-1:0]      last_tt_reg;
   logic                 reset_pend_reg;
   logic                 ret_pend_reg;
   ret_kind_t            ret_kind_reg;
   logic [TL_W-1:0]      rd_level;
   logic [TL_W-1:0]      wr_level;
   logic                 took_term;
   pc_pair_t             stack_rd;
   pc_pair_t             stack_wr;
   logic                 stack_we;

   irq_sync u_sync (
      .core_clk_in (core_clk_in),
      .nrst_in     (nrst_in),
      .raw_in      (ext_irq_in),
      .level_out   (ext_level)
   );

   // combined request levels; soft bits stay until cleared, external lines follow their sources
   logic [NUM_IRQ:1] irq_req;
   assign irq_req = soft_interrupt_request_reg | ext_level;

   // highest pending interrupt level; higher level wins
   logic [LEVEL_W-1:0] top_level;
   always_comb begin
      top_level = '0;
      for (int i = 1; i <= NUM_IRQ; i++)
         if (irq_req[i])
            top_level = LEVEL_W'(i);
   end

   // masking against the mode of this boundary, not of detection
   logic sup_ok;
   logic irq_ok;
   assign sup_ok = (priv_reg != MODE_HYPER) && global_interrupt_enable_reg;
   assign irq_ok = sup_ok && (top_level > processor_interrupt_threshold_reg);

   // nesting at the limit pushes the trap up to hyperprivileged mode
   logic irq_hyper;
   assign irq_hyper = trap_nesting_level_reg >= MAX_SUPERVISOR_NESTING;

   // priority select at each boundary
   trap_take_t sel;
   always_comb begin
      sel = '0;
      sel.level = trap_nesting_level_reg;
      sel.saved = cur_pc_in;
      if (reset_pend_reg) begin
         sel.valid = 1'b1;
         sel.cat = CAT_RESET;
         sel.tt = TT_RESET;
         sel.to_hyper = 1'b1;
      end else if ((def_pend_reg && def_term_reg)
                   || term_def_in) begin
         sel.valid = 1'b1;
         sel.cat = CAT_TERM_DEF;
         sel.tt = TT_TERM_DEF;
         sel.to_hyper = 1'b1;
         // a fresh termination error is taken in the cycle it arrives
         sel.saved = term_def_in ? def_pc_in : def_pc_reg;
      end else if (boundary_in && exc_valid_in) begin
         sel.valid = 1'b1;
         sel.cat = CAT_PRECISE;
         sel.tt = exc_tt_in;
         sel.saved = cur_pc_in;
      end else if (boundary_in && def_pend_reg && drain_def_in) begin
         sel.valid = 1'b1;
         sel.cat = CAT_RSTRT_DEF;
         sel.tt = TT_RESTART_DEF;
         sel.to_hyper = 1'b1;
         sel.saved = def_pc_reg;
      end else if (boundary_in && hyper_irq_in
                   && priv_reg != MODE_HYPER) begin
         sel.valid = 1'b1;
         sel.cat = CAT_DISRUPT;
         sel.tt = TT_HYPER_INT;
         sel.to_hyper = 1'b1;
      end else if (boundary_in && irq_ok) begin
         sel.valid = 1'b1;
         sel.cat = CAT_DISRUPT;
         sel.tt = TT_IRQ_BASE + TT_W'(top_level);
         sel.to_hyper = irq_hyper;
         sel.saved = cur_pc_in;
      end
      if (trap_nesting_level_reg >= MAX_TRAP_LEVEL && sel.cat != CAT_RESET)
         sel.valid = 1'b0;
   end

   // reset traps latch asynchronously to the instruction stream
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in)
         reset_pend_reg <= 1'b1;
      else if (sys_reset_req_in)
         reset_pend_reg <= 1'b1;
      else if (sel.cat == CAT_RESET)
         reset_pend_reg <= 1'b0;
   end

   // deferred exception capture, with issuing mode for reporting
   // a new error wins over the clear of the one being taken
   assign took_term = sel.valid && sel.cat == CAT_TERM_DEF;
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         def_pend_reg <= 1'b0;
         def_term_reg <= 1'b0;
         def_pc_reg <= '0;
         def_mode_reg <= MODE_USER;
      end else if ((term_def_in && !took_term) || rstrt_def_in) begin
         def_pend_reg <= 1'b1;
         def_term_reg <= !took_term && (term_def_in || def_term_reg);
         def_pc_reg <= def_pc_in;
         def_mode_reg <= priv_reg;
      end else if (took_term || (sel.valid && (sel.cat == CAT_RSTRT_DEF
                                             || sel.cat == CAT_RESET))) begin
         def_pend_reg <= 1'b0;
         def_term_reg <= 1'b0;
      end
   end

   // nesting level moves on trap and return; privilege moves on trap and on a control write
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         trap_nesting_level_reg <= '0;
         priv_reg <= MODE_HYPER;
         last_tt_reg <= '0;
      end else if (sel.valid && sel.cat == CAT_RESET) begin
         trap_nesting_level_reg <= MAX_TRAP_LEVEL;
         priv_reg <= MODE_HYPER;
         last_tt_reg <= TT_RESET;
      end else if (sel.valid) begin
         trap_nesting_level_reg <= trap_nesting_level_reg + 3'h1;
         priv_reg <= sel.to_hyper ? MODE_HYPER : MODE_PRIV;
         last_tt_reg <= sel.tt;
      end else if (ret_pend_reg && trap_nesting_level_reg != '0) begin
         trap_nesting_level_reg <= trap_nesting_level_reg - 3'h1;
      end else if (reg_wr_in && reg_addr_in == REG_CTRL) begin
         priv_reg <= priv_mode_t'(reg_wdata_in[CTRL_PRIV_LSB +: 2]);
      end
   end

   // saved counter stack: write on every trap but reset, read on return
   assign stack_we = sel.valid && sel.cat != CAT_RESET;
   assign stack_wr = sel.saved;
   // entry n holds the pair saved on the way into level n
   assign wr_level = trap_nesting_level_reg + 3'h1;
   assign rd_level = trap_nesting_level_reg;

   trap_stack u_stack (
      .core_clk_in (core_clk_in),
      .wr_addr_in  (wr_level),
      .wr_en_in    (stack_we),
      .wr_data_in  (stack_wr),
      .rd_addr_in  (rd_level),
      .rd_data_out (stack_rd)
   );

   // return: one cycle to read the stack, then redirect
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ret_pend_reg <= 1'b0;
         ret_kind_reg <= RET_NONE;
      end else if (!ret_pend_reg && !sel.valid
                   && (ret_retry_in || ret_done_in)) begin
         ret_pend_reg <= 1'b1;
         ret_kind_reg <= ret_retry_in ? RET_RETRY : RET_DONE;
      end else begin
         ret_pend_reg <= 1'b0;
         ret_kind_reg <= RET_NONE;
      end
   end

   // outputs, all registered
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         trap_take_out <= '0;
         flush_younger_out <= 1'b0;
         commit_block_out <= 1'b0;
         redirect_out <= 1'b0;
         redirect_pc_out <= '0;
         ret_busy_out <= 1'b0;
      end else begin
         trap_take_out <= sel;
         // younger flushed, faulting one never commits
         flush_younger_out <= sel.valid;
         commit_block_out <= sel.valid && (sel.cat == CAT_PRECISE
                                           || multi_load_first_in);
         // an ignored return must not look busy
         ret_busy_out <= !ret_pend_reg && !sel.valid
                         && (ret_retry_in || ret_done_in);
         redirect_out <= 1'b0;
         if (sel.valid && sel.cat == CAT_RESET) begin
            redirect_out <= 1'b1;
            redirect_pc_out.pc <= RESET_VECTOR;
            redirect_pc_out.next_program_counter <= RESET_VECTOR + INSTR_BYTES;
         end else if (ret_pend_reg && ret_kind_reg == RET_RETRY) begin
            redirect_out <= 1'b1;
            redirect_pc_out <= stack_rd;
         end else if (ret_pend_reg && ret_kind_reg == RET_DONE) begin
            redirect_out <= 1'b1;
            redirect_pc_out.pc <= stack_rd.next_program_counter;
            redirect_pc_out.next_program_counter <= stack_rd.next_program_counter + INSTR_BYTES;
         end
      end
   end

   // control register: enable and threshold
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         global_interrupt_enable_reg <= 1'b0;
         processor_interrupt_threshold_reg <= THRESH_RESET;
      end else if (sel.valid) begin
         // trap entry masks further supervisor interrupts
         global_interrupt_enable_reg <= 1'b0;
      end else if (reg_wr_in && reg_addr_in == REG_CTRL) begin
         global_interrupt_enable_reg <= reg_wdata_in[CTRL_IE_BIT];
         processor_interrupt_threshold_reg <=
            reg_wdata_in[CTRL_PIL_LSB +: LEVEL_W];
      end
   end

   // soft interrupt bits: set by write, held until software clears
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in)
         soft_interrupt_request_reg <= '0;
      else if (reg_wr_in && reg_addr_in == REG_SOFT_INTERRUPT_REQUEST_REG)
         soft_interrupt_request_reg <= soft_interrupt_request_reg
                                       | reg_wdata_in[NUM_IRQ:1];
      else if (reg_wr_in && reg_addr_in == REG_SOFTCLR)
         soft_interrupt_request_reg <= soft_interrupt_request_reg
                                       & ~reg_wdata_in[NUM_IRQ:1];
   end

   // read port, data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in)
         reg_rdata_out <= '0;
      else if (reg_rd_in) begin
         case (reg_addr_in)
            // priv reads back in 9:8, where it is written
            REG_CTRL: reg_rdata_out <= 32'({priv_reg,
               processor_interrupt_threshold_reg,
               3'h0, global_interrupt_enable_reg});
            REG_SOFT_INTERRUPT_REQUEST_REG: reg_rdata_out <= 32'({soft_interrupt_request_reg,
                                               1'b0});
            REG_STATUS: reg_rdata_out <= 32'({irq_req, 1'b0})
               | {13'h0, trap_nesting_level_reg, 16'h0};
            REG_DEFINFO: reg_rdata_out <= 32'({def_mode_reg, def_term_reg,
                                               def_pend_reg});
            REG_TTYPE: reg_rdata_out <= 32'(last_tt_reg);
            default: reg_rdata_out <= 32'h00000000;
         endcase
      end else
         reg_rdata_out <= 32'h00000000;
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         priv_out <= MODE_HYPER;
         trap_nesting_level_out <= '0;
      end else begin
         priv_out <= priv_reg;
         trap_nesting_level_out <= trap_nesting_level_reg;
      end
   end
endmodule : trap_category_control

/* File: verification/trap_category_control_chk.sv */
// trap_category_control_chk: port-level checks of trap taking and returns
// assumes bound to trap_category_control, single clock domain
`timescale 1ns/1ps
module trap_category_control_chk
   import trap_ctl_pkg::*;
(
   input  wire logic            core_clk_in,
   input  wire logic            nrst_in,
   input  wire logic            boundary_in,
   input  wire pc_pair_t        cur_pc_in,
   input  wire logic            exc_valid_in,
   input  wire logic            term_def_in,
   input  wire logic            drain_def_in,
   input  wire logic            ret_retry_in,
   input  wire logic            ret_done_in,
   input  wire logic            hyper_irq_in,
   input  wire logic            sys_reset_req_in,
   input  wire trap_take_t      trap_take_out,
   input  wire logic            flush_younger_out,
   input  wire logic            commit_block_out,
   input  wire logic            redirect_out,
   input  wire pc_pair_t        redirect_pc_out,
   input  wire logic            ret_busy_out,
   input  wire priv_mode_t      priv_out,
   input  wire logic [TL_W-1:0] trap_nesting_level_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   // quiet cycle: nothing in flight, room left on the trap stack
   logic idle;
   assign idle = !trap_take_out.valid && !ret_busy_out && !redirect_out &&
                 !sys_reset_req_in && trap_nesting_level_out < MAX_TRAP_LEVEL;
   sequence taken(trap_cat_t c);
      trap_take_out.valid && trap_take_out.cat == c;
   endsequence
   sequence ret_walk;
      ret_busy_out ##1 redirect_out;
   endsequence
   precise_take_a:
   assert property (idle && boundary_in && exc_valid_in && !term_def_in |=>
      taken(CAT_PRECISE) ##0 (trap_take_out.saved == $past(cur_pc_in)))
      else $error("precise trap not taken with its counters");
   precise_flush_a:
   assert property (taken(CAT_PRECISE) |-> flush_younger_out && commit_block_out)
      else $error("precise trap without flush and commit block");
   disrupt_flush_a:
   assert property (taken(CAT_DISRUPT) |-> flush_younger_out)
      else $error("disrupting trap without flush");
   deferred_hyper_a:
   assert property (trap_take_out.valid && (trap_take_out.cat == CAT_TERM_DEF
      || trap_take_out.cat == CAT_RSTRT_DEF) |-> trap_take_out.to_hyper)
      else $error("deferred trap not sent to hyper mode");
   term_take_a:
   assert property (idle && term_def_in |=> taken(CAT_TERM_DEF))
      else $error("termination deferred trap not taken first");
   hyper_irq_a:
   assert property (idle && boundary_in && hyper_irq_in && !exc_valid_in &&
      !term_def_in && !drain_def_in && priv_out != MODE_HYPER |=>
      taken(CAT_DISRUPT) ##0 trap_take_out.to_hyper)
      else $error("hyper interrupt not delivered at once");
   ret_walk_a:
   assert property ((ret_retry_in || ret_done_in) && !ret_busy_out &&
      !redirect_out && !trap_take_out.valid && !sys_reset_req_in |=> ret_walk)
      else $error("return did not redirect two cycles later");
   done_pair_a:
   assert property (redirect_out && $past(ret_done_in, 2) |->
      redirect_pc_out.next_program_counter == redirect_pc_out.pc + INSTR_BYTES)
      else $error("done return pair not npc and npc plus 4");
   reset_vec_a:
   assert property (taken(CAT_RESET) |->
      redirect_out && redirect_pc_out.pc == RESET_VECTOR)
      else $error("reset trap not vectored to reset address");
   nest_limit_a:
   assert property (taken(CAT_DISRUPT) ##0 !trap_take_out.to_hyper |->
      $past(trap_nesting_level_out) < MAX_SUPERVISOR_NESTING)
      else $error("supervisor delivery at too deep a nesting level");
endmodule : trap_category_control_chk
bind trap_category_control trap_category_control_chk chk_i (.*);

/* File: verification/irq_source_model.sv */
// irq_source_model: external and hyper interrupt sources of the controller
// assumes set and clear pulses from the bench, core clock only
`timescale 1ns/1ps
module irq_source_model
   import trap_ctl_pkg::*;
(
   input  wire logic               core_clk_in,
   input  wire logic               nrst_in,
   input  wire logic [NUM_IRQ-1:0] set_in,
   input  wire logic [NUM_IRQ-1:0] clr_in,
   input  wire logic               hyp_set_in,
   input  wire logic               hyp_clr_in,
   output logic      [NUM_IRQ-1:0] ext_irq_out,
   output logic                    hyper_irq_out
);
   // a line stays up until its source drops it
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ext_irq_out   <= '0;
         hyper_irq_out <= 1'b0;
      end else begin
         ext_irq_out   <= (ext_irq_out | set_in) & ~clr_in;
         hyper_irq_out <= (hyper_irq_out | hyp_set_in) & !hyp_clr_in;
      end
   end
endmodule : irq_source_model

/* File: verification/trap_category_control_tb.sv */
// trap_category_control_tb: directed trap, return and masking sequences
// assumes irq_source_model drives the interrupt lines
`timescale 1ns/1ps
module trap_category_control_tb
   import trap_ctl_pkg::*;
();
   logic               core_clk_in, nrst_in, reg_wr_in, reg_rd_in;
   logic [3:0]         reg_addr_in;
   logic [31:0]        reg_wdata_in, reg_rdata_out;
   logic               boundary_in, exc_valid_in, multi_load_first_in;
   logic               term_def_in, rstrt_def_in, drain_def_in;
   logic               ret_retry_in, ret_done_in, sys_reset_req_in;
   logic               hyper_irq_in, hyp_set, hyp_clr;
   logic               redirect_out, ret_busy_out;
   logic               flush_younger_out, commit_block_out;
   logic [TT_W-1:0]    exc_tt_in;
   logic [NUM_IRQ-1:0] ext_irq_in, irq_set, irq_clr;
   logic [TL_W-1:0]    trap_nesting_level_out;
   pc_pair_t           cur_pc_in, def_pc_in, redirect_pc_out, rp;
   trap_take_t         trap_take_out, got;
   priv_mode_t         priv_out;
   int                 n_fail, n_checks;
   trap_category_control uut (.*);
   irq_source_model irq_src (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
      .set_in(irq_set), .clr_in(irq_clr), .hyp_set_in(hyp_set),
      .hyp_clr_in(hyp_clr), .ext_irq_out(ext_irq_in),
      .hyper_irq_out(hyper_irq_in));
   always #2.5 core_clk_in = ~core_clk_in;
   task automatic summarize();
      if (n_fail == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1 chk(reg_rdata_out, e);
   endtask : rd
   // one boundary cycle; v = exc, multi load, term, restart, drain, reset
   task automatic bp(input logic [5:0] v);
      @(posedge core_clk_in);
      {exc_valid_in, multi_load_first_in, term_def_in, rstrt_def_in,
       drain_def_in, sys_reset_req_in} <= v;
      boundary_in <= 1'b1;
      @(posedge core_clk_in);
      {exc_valid_in, multi_load_first_in, term_def_in, rstrt_def_in,
       drain_def_in, sys_reset_req_in, boundary_in} <= '0;
   endtask : bp
   task automatic lines(input logic [15:0] s, input logic [15:0] c);
      @(posedge core_clk_in);
      {hyp_set, irq_set} <= s;
      {hyp_clr, irq_clr} <= c;
      @(posedge core_clk_in);
      {hyp_set, irq_set, hyp_clr, irq_clr} <= '0;
   endtask : lines
   // bounded wait for a trap; level is looked at once it has settled
   task automatic tr(input trap_cat_t c, input logic [TL_W-1:0] l);
      int i;
      #1;
      for (i = 0; i < 60 && trap_take_out.valid !== 1'b1; i++) begin
         @(posedge core_clk_in);
         #1;
      end
      if (i == 60) begin
         n_fail++;
         summarize();
      end
      got = trap_take_out;
      rp  = redirect_pc_out;
      chk(got.cat, c);
      @(posedge core_clk_in);
      #1 chk(trap_nesting_level_out, l);
   endtask : tr
   task automatic none(input int n);
      repeat (n) begin
         @(posedge core_clk_in);
         #1 chk(trap_take_out.valid, 1'b0);
      end
   endtask : none
   task automatic ret(input logic d, input logic [TL_W-1:0] l);
      @(posedge core_clk_in);
      ret_done_in  <= d;
      ret_retry_in <= !d;
      @(posedge core_clk_in);
      {ret_done_in, ret_retry_in} <= '0;
      @(posedge core_clk_in);
      #1 chk(redirect_out, 1'b1);
      rp = redirect_pc_out;
      @(posedge core_clk_in);
      #1 chk(trap_nesting_level_out, l);
   endtask : ret
   initial begin
      {core_clk_in, nrst_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in,
       boundary_in, exc_valid_in, multi_load_first_in, term_def_in,
       rstrt_def_in, drain_def_in, ret_retry_in, ret_done_in,
       sys_reset_req_in, cur_pc_in, def_pc_in, irq_set, irq_clr, hyp_set,
       hyp_clr} = '0;
      exc_tt_in = 9'h010;
      n_fail    = 0;
      n_checks  = 0;
      repeat (2) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      tr(CAT_RESET, 3'h6);
      chk(rp.pc, RESET_VECTOR);
      chk(priv_out, MODE_HYPER);
      rd(REG_CTRL, 32'h000002F0);
      rd(4'hF, 32'h00000000);
      for (int k = 5; k >= 0; k--) ret(1'b0, 3'(k));
      wr(REG_CTRL, 32'h00000031);
      wr(REG_SOFT_INTERRUPT_REQUEST_REG, 32'h00000008);
      bp(6'h00);
      none(4);
      wr(REG_CTRL, 32'h00000020);
      bp(6'h00);
      none(4);
      cur_pc_in <= {64'h2000, 64'h2004};
      wr(REG_CTRL, 32'h00000021);
      bp(6'h00);
      tr(CAT_DISRUPT, 3'h1);
      chk(got.tt, TT_IRQ_BASE + 9'h003);
      chk(got.saved, {64'h2000, 64'h2004});
      rd(REG_STATUS, 32'h00010008);
      wr(REG_SOFTCLR, 32'h00000008);
      cur_pc_in <= {64'h1000, 64'h1004};
      bp(6'h30);
      tr(CAT_PRECISE, 3'h2);
      chk(got.saved, {64'h1000, 64'h1004});
      ret(1'b1, 3'h1);
      chk(rp, {64'h1004, 64'h1008});
      bp(6'h20);
      tr(CAT_PRECISE, 3'h2);
      ret(1'b0, 3'h1);
      chk(rp, {64'h1000, 64'h1004});
      // levels 5 and 2 up, threshold 2: only level 5 may win
      wr(REG_CTRL, 32'h00000121);
      lines(16'h0012, 16'h0000);
      repeat (6) @(posedge core_clk_in);
      bp(6'h00);
      tr(CAT_DISRUPT, 3'h2);
      chk(got.tt, TT_IRQ_BASE + 9'h005);
      lines(16'h0000, 16'h0010);
      wr(REG_CTRL, 32'h00000101);
      bp(6'h00);
      tr(CAT_DISRUPT, 3'h3);
      chk(got.to_hyper, 1'b1);
      lines(16'h0000, 16'h0002);
      wr(REG_CTRL, 32'h00000000);
      lines(16'h8000, 16'h0000);
      bp(6'h00);
      tr(CAT_DISRUPT, 3'h4);
      chk(got.tt, TT_HYPER_INT);
      lines(16'h0000, 16'h8000);
      def_pc_in <= {64'h3000, 64'h3004};
      bp(6'h28);
      tr(CAT_TERM_DEF, 3'h5);
      chk(got.to_hyper, 1'b1);
      bp(6'h04);
      none(2);
      rd(REG_DEFINFO, 32'h00000009);
      bp(6'h02);
      tr(CAT_RSTRT_DEF, 3'h6);
      chk(got.saved, {64'h3000, 64'h3004});
      chk(got.to_hyper, 1'b1);
      rd(REG_TTYPE, 32'(TT_RESTART_DEF));
      bp(6'h01);
      tr(CAT_RESET, 3'h6);
      chk(rp.pc, RESET_VECTOR);
      summarize();
   end
endmodule : trap_category_control_tb
